// ---- inc/mspseq_consts.svh ----
// Purpose: constants of the multiplexer scan sequencer
// Assumes: one sequence entry is one 16-bit word pair
// Notes: low byte is the channel/port word, high byte the gain/channel word
`ifndef MSPSEQ_CONSTS_SVH
`define MSPSEQ_CONSTS_SVH

`define MSPSEQ_ADDR_W 10
`define MSPSEQ_DEPTH 1024
`define MSPSEQ_ENTRY_W 16
`define MSPSEQ_CONV_W 16
// channel/port word fields
`define MSPSEQ_PORT_LSB 0
`define MSPSEQ_CHLO_LSB 3
`define MSPSEQ_CTRL_LSB 6
// gain/channel word fields
`define MSPSEQ_CHHI_LSB 8
`define MSPSEQ_GAIN_LSB 11
`define MSPSEQ_TRIG_BIT 13
// control codes, then the output buffer depth
`define MSPSEQ_CTRL_LOOP 2'h0
`define MSPSEQ_CTRL_TRACK 2'h1
`define MSPSEQ_CTRL_HOLD 2'h3
`define MSPSEQ_BUF_DEPTH 2'h2

`endif

// ---- inc/mspseq_pkg.sv ----
// Purpose: types of the multiplexer scan sequencer
// Assumes: constants come from mspseq_consts.svh
// Notes: none
`include "mspseq_consts.svh"
package mspseq_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_CONV
  } mspseq_state_e;

  typedef struct packed {
    logic [1:0] ctrl;
    logic trig;
    logic [1:0] gain;
    logic [2:0] port;
    logic [4:0] chan;
  } mspseq_entry_s;

  typedef struct packed {
    logic trig;
    logic [2:0] port;
    logic [4:0] chan;
    logic [`MSPSEQ_CONV_W-1:0] conv;
  } mspseq_sample_s;

endpackage

// ---- rtl/mspseq_ram.sv ----
// Purpose: sequence memory, one entry pair per word
// Assumes: single clock, one write and one read port
// Notes: read data registered, one cycle after the address
`timescale 1ns/1ps
`include "mspseq_consts.svh"
module mspseq_ram (
  // clock
  input wire logic clk_i,
  // write side
  input wire logic we_i,
  input wire logic [`MSPSEQ_ADDR_W-1:0] waddr_i,
  input wire logic [`MSPSEQ_ENTRY_W-1:0] wdata_i,
  // read side
  input wire logic [`MSPSEQ_ADDR_W-1:0] raddr_i,
  output logic [`MSPSEQ_ENTRY_W-1:0] rdata_o
);

  logic [`MSPSEQ_ENTRY_W-1:0] mem_q [0:`MSPSEQ_DEPTH-1];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end

endmodule

// ---- rtl/mspseq_top.sv ----
// Purpose: scan sequencer driving pipelined multiplexer cards
// Assumes: ADC answers each convert pulse once with ADC_VALID_I
// Notes: preload and table reordering are the host's job
`timescale 1ns/1ps
`include "mspseq_consts.svh"
module mspseq_top (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic SRST_I,
  // control
  input wire logic RUN_I,
  input wire logic SAMPLE_TICK_I,
  // sequence memory load
  input wire logic TBL_WE_I,
  input wire logic [`MSPSEQ_ADDR_W-1:0] TBL_ADDR_I,
  input wire logic [`MSPSEQ_ENTRY_W-1:0] TBL_DATA_I,
  // converter
  input wire logic ADC_VALID_I,
  input wire logic [`MSPSEQ_CONV_W-1:0] ADC_DATA_I,
  output logic CONVERT_O,
  output logic [1:0] GAIN_O,
  // multiplexer lines
  output logic [2:0] MUX_PORT_O,
  output logic [4:0] MUX_CHAN_O,
  output logic MUX_LOAD_O,
  output logic EXT_SH_O,
  // sample stream
  output mspseq_pkg::mspseq_sample_s DATA_O,
  output logic DATA_VALID_O,
  input wire logic DATA_READY_I,
  // status
  output logic BUSY_O,
  output logic OVERRUN_O,
  output logic [`MSPSEQ_ADDR_W-1:0] SEQ_ADDR_O
);

  function automatic mspseq_pkg::mspseq_entry_s decode(input logic [`MSPSEQ_ENTRY_W-1:0] w);
    mspseq_pkg::mspseq_entry_s e;
    e.ctrl = w[`MSPSEQ_CTRL_LSB +: 2];
    e.trig = w[`MSPSEQ_TRIG_BIT];
    e.gain = w[`MSPSEQ_GAIN_LSB +: 2];
    e.port = w[`MSPSEQ_PORT_LSB +: 3];
    e.chan = {w[`MSPSEQ_CHHI_LSB +: 2], w[`MSPSEQ_CHLO_LSB +: 3]};
    return e;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // sample tick synchroniser, tick is a pin
  logic tk1_q, tk2_q, tk3_q;
  logic tick;

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      tk1_q <= 1'b0;
      tk2_q <= 1'b0;
      tk3_q <= 1'b0;
    end else begin
      tk1_q <= SAMPLE_TICK_I;
      tk2_q <= tk1_q;
      tk3_q <= tk2_q;
    end
  end

  assign tick = tk2_q & ~tk3_q;

  ////////////////////////////////////////////////////////////////////////////
  // sequence memory
  logic [`MSPSEQ_ENTRY_W-1:0] rdata;
  mspseq_pkg::mspseq_entry_s ent;
  logic [`MSPSEQ_ADDR_W-1:0] addr_q, addr_d;

  mspseq_ram u_ram (
    .clk_i(MCLK_I),
    .we_i(TBL_WE_I),
    .waddr_i(TBL_ADDR_I),
    .wdata_i(TBL_DATA_I),
    .raddr_i(addr_q),
    .rdata_o(rdata)
  );

  assign ent = decode(rdata);

  ////////////////////////////////////////////////////////////////////////////
  // buffer state, declared early for the stall term
  logic [1:0] cnt_q, cnt_d;
  logic push, pop, buf_full;

  assign buf_full = (cnt_q == `MSPSEQ_BUF_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  mspseq_pkg::mspseq_state_e st_q, st_d;
  mspseq_pkg::mspseq_entry_s cur_q, cur_d;
  logic store_q, store_d;
  logic load_q, load_d, conv_q, conv_d, sh_q, sh_d, ovr_q, ovr_d;

  always_comb begin
    st_d = st_q;
    cur_d = cur_q;
    store_d = store_q;
    addr_d = addr_q;
    load_d = 1'b0;
    conv_d = 1'b0;
    sh_d = sh_q;
    ovr_d = ovr_q;
    case (st_q)
      mspseq_pkg::ST_IDLE: begin
        if (!RUN_I) begin
          // stop only here, after the period's conversion closed
          addr_d = '0;
          ovr_d = 1'b0;
        end else if (tick) begin
          // a full buffer stalls this period rather than drop a word
          if (buf_full) begin
            ovr_d = 1'b1;
          end else begin
            st_d = mspseq_pkg::ST_FETCH;
          end
        end
      end
      mspseq_pkg::ST_FETCH: begin
        cur_d = ent;
        load_d = 1'b1;
        conv_d = 1'b1;
        // track entries use their period but keep nothing
        store_d = (ent.ctrl != `MSPSEQ_CTRL_TRACK);
        if (ent.ctrl == `MSPSEQ_CTRL_TRACK) begin
          sh_d = 1'b1;
        end else if (ent.ctrl == `MSPSEQ_CTRL_HOLD) begin
          sh_d = 1'b0;
        end
        if (ent.ctrl == `MSPSEQ_CTRL_LOOP) begin
          addr_d = '0;
        end else begin
          addr_d = addr_q + 1'b1;
        end
        st_d = mspseq_pkg::ST_CONV;
      end
      mspseq_pkg::ST_CONV: begin
        if (tick) begin
          ovr_d = 1'b1;
        end
        if (ADC_VALID_I) begin
          st_d = mspseq_pkg::ST_IDLE;
        end
      end
      default: begin
        st_d = mspseq_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      st_q <= mspseq_pkg::ST_IDLE;
      cur_q <= '0;
      store_q <= 1'b0;
      addr_q <= '0;
      load_q <= 1'b0;
      conv_q <= 1'b0;
      sh_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cur_q <= cur_d;
      store_q <= store_d;
      addr_q <= addr_d;
      load_q <= load_d;
      conv_q <= conv_d;
      sh_q <= sh_d;
      ovr_q <= ovr_d;
    end
  end

  // codes stay on the lines after a stop
  assign MUX_PORT_O = cur_q.port;
  assign MUX_CHAN_O = cur_q.chan;
  assign GAIN_O = cur_q.gain;
  assign MUX_LOAD_O = load_q;
  assign CONVERT_O = conv_q;
  assign EXT_SH_O = sh_q;
  assign OVERRUN_O = ovr_q;
  assign SEQ_ADDR_O = addr_q;

  ////////////////////////////////////////////////////////////////////////////
  // two-entry output buffer
  mspseq_pkg::mspseq_sample_s b0_q, b0_d, b1_q, b1_d, nw;
  logic vld_q, vld_d, busy_q, busy_d;

  assign push = (st_q == mspseq_pkg::ST_CONV) && ADC_VALID_I && store_q;
  assign pop = vld_q && DATA_READY_I;

  always_comb begin
    nw = '{trig: cur_q.trig, port: cur_q.port, chan: cur_q.chan, conv: ADC_DATA_I};
    b0_d = b0_q;
    b1_d = b1_q;
    cnt_d = cnt_q;
    case ({push, pop})
      2'h2: begin
        if (cnt_q == 2'h0) begin
          b0_d = nw;
        end else begin
          b1_d = nw;
        end
        cnt_d = cnt_q + 2'h1;
      end
      2'h1: begin
        b0_d = b1_q;
        cnt_d = cnt_q - 2'h1;
      end
      2'h3: begin
        if (cnt_q == 2'h1) begin
          b0_d = nw;
        end else begin
          b0_d = b1_q;
          b1_d = nw;
        end
      end
      default: begin
        cnt_d = cnt_q;
      end
    endcase
    vld_d = (cnt_d != 2'h0);
    busy_d = RUN_I || (st_d != mspseq_pkg::ST_IDLE);
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      b0_q <= '0;
      b1_q <= '0;
      cnt_q <= 2'h0;
      vld_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      b0_q <= b0_d;
      b1_q <= b1_d;
      cnt_q <= cnt_d;
      vld_q <= vld_d;
      busy_q <= busy_d;
    end
  end

  assign DATA_O = b0_q;
  assign DATA_VALID_O = vld_q;
  assign BUSY_O = busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (SRST_I);

  load_one_shot_a: assert property (MUX_LOAD_O |=> !MUX_LOAD_O)
    else $error("mux load longer than one cycle");
  loop_to_zero_a: assert property (st_q == mspseq_pkg::ST_FETCH && ent.ctrl == 2'h0
    |=> SEQ_ADDR_O == '0) else $error("loop code did not return to zero");
  addr_advance_a: assert property (st_q == mspseq_pkg::ST_FETCH && ent.ctrl != 2'h0
    |=> SEQ_ADDR_O == $past(addr_q) + 1'b1) else $error("address did not advance");
  sh_track_a: assert property (st_q == mspseq_pkg::ST_FETCH && ent.ctrl == 2'h1
    |=> EXT_SH_O && MUX_LOAD_O) else $error("sample/hold not tracking");
  sh_hold_a: assert property (st_q == mspseq_pkg::ST_FETCH && ent.ctrl == 2'h3
    |=> !EXT_SH_O) else $error("sample/hold not holding");
  code_issue_a: assert property (st_q == mspseq_pkg::ST_FETCH
    |=> MUX_LOAD_O && CONVERT_O && MUX_PORT_O == $past(ent.port)
    && MUX_CHAN_O == $past(ent.chan)) else $error("issued codes differ from entry");
  track_drop_a: assert property (st_q == mspseq_pkg::ST_CONV && cur_q.ctrl == 2'h1
    && ADC_VALID_I |=> cnt_q <= $past(cnt_q)) else $error("track entry conversion stored");
  stop_bound_a: assert property (st_q == mspseq_pkg::ST_IDLE && !RUN_I
    |=> !MUX_LOAD_O ##1 !MUX_LOAD_O) else $error("entry issued after stop");
  buf_bound_a: assert property (cnt_q <= 2'h2 && (DATA_VALID_O == (cnt_q != 2'h0)))
    else $error("buffer count out of range");

  loop_wrap_c: cover property (st_q == mspseq_pkg::ST_FETCH && ent.ctrl == 2'h0);
  track_then_hold_c: cover property (EXT_SH_O ##[1:50] !EXT_SH_O);
  buf_full_c: cover property (buf_full && !DATA_READY_I);

endmodule

// ---- test/mspseq_mux_model.sv ----
// Purpose: multiplexer cards with channel registers, plus the converter
// Assumes: one card on each of the eight ports
// Notes: converter returns {port, channel} of the input it converted
`timescale 1ns/1ps
module mspseq_mux_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // multiplexer lines
  input wire logic [2:0] port_i,
  input wire logic [4:0] chan_i,
  input wire logic load_i,
  // converter
  input wire logic conv_i,
  input wire logic slow_i,
  output logic valid_o,
  output logic [15:0] data_o,
  output logic [7:0][4:0] reg_o
);
  logic [3:0] cnt;
  logic [15:0] res;
  always @(posedge clk_i) begin
    valid_o <= 1'b0;
    if (rst_i) begin
      reg_o <= '0;
      cnt <= 4'h0;
      data_o <= 16'hffff;
    end else begin
      // only the card whose port matches takes the code
      if (load_i) begin
        reg_o[port_i] <= chan_i;
      end
      // converts what was latched before this load
      if (conv_i) begin
        res <= {8'h00, port_i, reg_o[port_i]};
        cnt <= slow_i ? 4'h6 : 4'h2;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h1) begin
          valid_o <= 1'b1;
          data_o <= res;
        end
      end else begin
        // idle data line never keeps the last word
        data_o <= ~data_o;
      end
    end
  end
endmodule

// ---- test/mspseq_tb.sv ----
// Purpose: self-checking bench of the scan sequencer
// Assumes: sample tick every 20 clocks, model answers each convert
// Notes: ticks stay 20 clocks apart so the converter is always free
`timescale 1ns/1ps
module mspseq_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b0;
  logic tick = 1'b0;
  logic we = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [15:0] wdat = 16'h0000;
  logic rdy = 1'b1;
  logic slow = 1'b0;
  logic avld, conv, load, sh, dvld, busy, ovr;
  logic [15:0] adat;
  logic [2:0] port;
  logic [4:0] chan;
  logic [9:0] sa;
  logic [7:0][4:0] cregs;
  mspseq_pkg::mspseq_sample_s dat;
  mspseq_pkg::mspseq_sample_s got[$];
  logic shq[$];
  logic [7:0] ldt[$];
  logic [7:0] dst[$];
  logic [1:0] gain;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  localparam logic [4:0] pre [3] = '{5'h01, 5'h06, 5'h03};
  localparam logic [2:0] pt [12] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h1,
    3'h2, 3'h2, 3'h2};
  localparam logic [4:0] ld [12] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h01, 5'h07, 5'h08,
    5'h09, 5'h06, 5'h04, 5'h05, 5'h03};
  localparam logic [4:0] ds [12] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
    5'h08, 5'h09, 5'h03, 5'h04, 5'h05};
  ////////////////////////////////////////////////////////////////////////////////
  mspseq_top DUT (
    .MCLK_I(clk), .SRST_I(rst), .RUN_I(run), .SAMPLE_TICK_I(tick),
    .TBL_WE_I(we), .TBL_ADDR_I(addr), .TBL_DATA_I(wdat),
    .ADC_VALID_I(avld), .ADC_DATA_I(adat), .CONVERT_O(conv), .GAIN_O(gain),
    .MUX_PORT_O(port), .MUX_CHAN_O(chan), .MUX_LOAD_O(load), .EXT_SH_O(sh),
    .DATA_O(dat), .DATA_VALID_O(dvld), .DATA_READY_I(rdy),
    .BUSY_O(busy), .OVERRUN_O(ovr), .SEQ_ADDR_O(sa)
  );
  mspseq_mux_model u_mux (
    .clk_i(clk), .rst_i(rst), .port_i(port), .chan_i(chan), .load_i(load),
    .conv_i(conv), .slow_i(slow), .valid_o(avld), .data_o(adat), .reg_o(cregs)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] act, input logic [15:0] exp);
    check_count++;
    if (act !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, act, exp);
    end
  endtask
  task automatic wr(input int a, input logic [1:0] c, input logic [2:0] p,
    input logic [4:0] ch, input logic [1:0] g = 2'h0, input logic tr = 1'b0);
    we = 1'b1;
    addr = a[9:0];
    wdat = {2'h0, tr, g, 1'b0, ch[4:3], c, ch[2:0], p};
    @(posedge clk);
    #1;
    we = 1'b0;
    // one idle edge, so back-to-back writes never retoggle the strobe in one step
    @(posedge clk);
    #1;
  endtask
  task automatic tk(input int n);
    repeat (n) begin
      tick = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      tick = 1'b0;
      repeat (17) @(posedge clk);
      #1;
    end
  endtask
  task automatic go(input int n);
    got.delete();
    shq.delete();
    run = 1'b1;
    tk(n);
    run = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // entries are {port, channel} bytes; preload data is thrown away by the next go
  task automatic preload(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    wr(0, 2'h3, a[7:5], a[4:0]);
    wr(1, 2'h3, b[7:5], b[4:0]);
    wr(2, 2'h0, c[7:5], c[4:0]);
    go(3);
    chk({11'h000, cregs[a[7:5]]}, {11'h000, a[4:0]});
    chk({11'h000, cregs[b[7:5]]}, {11'h000, b[4:0]});
    chk({11'h000, cregs[c[7:5]]}, {11'h000, c[4:0]});
  endtask
  task automatic scan();
    int n;
    n = ldt.size();
    for (int i = 0; i < n; i++) wr(i, (i == n - 1) ? 2'h0 : 2'h3, ldt[i][7:5], ldt[i][4:0]);
    slow = 1'b0;
    go(n);
    chk(16'(got.size()), 16'(n));
    for (int i = 0; i < n; i++) chk(got[i].conv, {8'h00, dst[i]});
  endtask
  task automatic t_pre();
    preload({3'h0, pre[0]}, {3'h1, pre[1]}, {3'h2, pre[2]});
    $display("test preload done");
  endtask
  task automatic t_stage2();
    // runs on the preload left by the single stage loop
    ldt = '{8'h02, 8'h27, 8'h03, 8'h28, 8'h04, 8'h44, 8'h05, 8'h29, 8'h01, 8'h45, 8'h26,
      8'h43};
    dst = '{8'h01, 8'h26, 8'h02, 8'h27, 8'h03, 8'h43, 8'h04, 8'h28, 8'h05, 8'h44, 8'h29,
      8'h45};
    scan();
    for (int i = 0; i < 3; i++) chk({11'h000, cregs[i]}, {11'h000, pre[i]});
    $display("test two stage done");
  endtask
  task automatic t_stage3();
    preload(8'h02, 8'h26, 8'h41);
    ldt = '{8'h03, 8'h27, 8'h43, 8'h04, 8'h28, 8'h44, 8'h05, 8'h29, 8'h45, 8'h02, 8'h26,
      8'h41};
    dst = '{8'h02, 8'h26, 8'h41, 8'h03, 8'h27, 8'h43, 8'h04, 8'h28, 8'h44, 8'h05, 8'h29,
      8'h45};
    scan();
    chk({1'b0, cregs[0], cregs[1], cregs[2]}, {1'b0, 5'h02, 5'h06, 5'h01});
    $display("test three stage done");
  endtask
  task automatic t_stage5();
    preload(8'h28, 8'h49, 8'h6d);
    // ports 5 and 7 are the dummies that pad the spacing
    ldt = '{8'h23, 8'h45, 8'h6d, 8'ha0, 8'he0,
      8'h22, 8'h4f, 8'h6d, 8'ha0, 8'he0,
      8'h20, 8'h47, 8'h6d, 8'ha0, 8'he0,
      8'h2c, 8'h41, 8'h6d, 8'ha0, 8'he0,
      8'h28, 8'h49, 8'h6d, 8'ha0, 8'he0};
    dst = '{8'h28, 8'h49, 8'h6d, 8'ha0, 8'he0,
      8'h23, 8'h45, 8'h6d, 8'ha0, 8'he0,
      8'h22, 8'h4f, 8'h6d, 8'ha0, 8'he0,
      8'h20, 8'h47, 8'h6d, 8'ha0, 8'he0,
      8'h2c, 8'h41, 8'h6d, 8'ha0, 8'he0};
    scan();
    chk({1'b0, cregs[1], cregs[2], cregs[3]}, {1'b0, 5'h08, 5'h09, 5'h0d});
    $display("test five stage done");
  endtask
  task automatic t_scan();
    for (int i = 0; i < 12; i++) wr(i, (i == 11) ? 2'h0 : 2'h3, pt[i], ld[i]);
    slow = 1'b1;
    go(24);
    chk(16'(got.size()), 16'h0018);
    for (int i = 0; i < 24; i++) chk(got[i].conv, {8'h00, pt[i % 12], ds[i % 12]});
    for (int i = 0; i < 3; i++) chk({11'h000, cregs[i]}, {11'h000, pre[i]});
    $display("test scan done");
  endtask
  task automatic t_sh();
    slow = 1'b0;
    wr(0, 2'h1, 3'h0, 5'h02);
    wr(1, 2'h1, 3'h0, 5'h02);
    wr(2, 2'h3, 3'h0, 5'h02);
    wr(3, 2'h0, 3'h1, 5'h07);
    go(4);
    chk(16'(shq.size()), 16'h0004);
    chk({12'h000, shq[0], shq[1], shq[2], shq[3]}, 16'h000c);
    chk(16'(got.size()), 16'h0002);
    chk(got[0].conv, 16'h0002);
    chk(got[1].conv, 16'h0026);
    $display("test sample hold done");
  endtask
  task automatic t_buf();
    wr(0, 2'h0, 3'h3, 5'h05, 2'h2, 1'b1);
    got.delete();
    rdy = 1'b0;
    run = 1'b1;
    // third tick finds both entries taken
    tk(3);
    chk({13'h0000, busy, ovr, dvld}, 16'h0007);
    run = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk({6'h00, gain, port, chan}, 16'h0265);
    rdy = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(16'(got.size()), 16'h0002);
    chk(got[0].conv, 16'h0060);
    chk(got[1].conv, 16'h0065);
    chk({15'h0000, got[0].trig}, 16'h0001);
    chk({13'h0000, busy, ovr, dvld}, 16'h0000);
    $display("test buffer done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dvld === 1'b1 && rdy === 1'b1) got.push_back(dat);
    if (load === 1'b1) shq.push_back(sh);
    if (cyc == 4000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    chk({6'h00, load, conv, dvld, ovr, sa[5:0]}, 16'h0000);
    $display("test reset done");
    t_pre();
    t_scan();
    t_stage2();
    t_sh();
    t_buf();
    t_stage3();
    t_stage5();
    results();
  end
endmodule
